// file: fsr_pkg.sv
// Package holding constants and types for the fault status and state readout bank
// Summary of operation
// - Clear needs status bit and clear bit together
// - Status reads one on fault, resets zero
// - Boost bit 15 thermal, bit 14 clears
// - Boost bit 13 current resistor short, 12 clears
// - Boost bit 11 string resistor missing, 10 clears
// - Boost bit 9 mode resistor missing, 8 clears
// - Boost bit 7 frequency resistor missing, 6 clears
// - Boost bit 5 overcurrent, 4 clears
// - Boost bit 3 overvoltage high, 2 clears
// - Boost bit 1 overvoltage low, 0 clears
// - String bit 14 bus timeout, 13 clears
// - String bit 12 bad configuration, 11 clears
// - String bit 10 combined fault, 9 clears
// - String bit 8 ground short, read only
// - String bit 7 internal short, read only
// - String bit 6 open string, read only
// - String bits 5..0 per-channel faults, read only
// - String bit 15 reserved, no function
// - Readout bits 4..0 give live state
// - Readout bits 15..5 read zero
// - Boost register at offset 10h, resets zero
package fsr_pkg;
  // Register indices, and byte addresses at four times the index
  localparam logic [11:0] FSR_IDX_BOOST = 12'h0010;
  localparam logic [11:0] FSR_IDX_STRING = 12'h0012;
  localparam logic [11:0] FSR_IDX_STATE = 12'h0014;
  localparam logic [11:0] FSR_ADDR_BOOST = 12'h0040;
  localparam logic [11:0] FSR_ADDR_STRING = 12'h0048;
  localparam logic [11:0] FSR_ADDR_STATE = 12'h0050;
  // Reset value of all status bits
  localparam logic [15:0] FSR_RST = 16'h0000;
  // Number of clearable flags per register
  localparam int FSR_NB = 8;
  localparam int FSR_NS = 3;
  // Lowest status bit position of the string register clearable flags
  localparam int FSR_S_BASE = 10;
  // Live state codes
  localparam logic [4:0] FSR_ST_DISABLED = 5'h00;
  localparam logic [4:0] FSR_ST_REG_STARTUP = 5'h01;
  localparam logic [4:0] FSR_ST_OTP_READ = 5'h02;
  localparam logic [4:0] FSR_ST_STANDBY = 5'h03;
  localparam logic [4:0] FSR_ST_CONV_START_LO = 5'h04;
  localparam logic [4:0] FSR_ST_CONV_START_HI = 5'h0f;
  localparam logic [4:0] FSR_ST_NORMAL = 5'h10;
  localparam logic [4:0] FSR_ST_SHUTDOWN = 5'h11;
  localparam logic [4:0] FSR_ST_RECOVERY = 5'h12;
  localparam logic [4:0] FSR_ST_ALL_FAILED = 5'h13;
  // Boost fault events, index 7 thermal down to 0 overvoltage low
  typedef struct packed {
    logic thermal_shutdown;
    logic current_resistor_short;
    logic string_cfg_resistor_missing;
    logic mode_resistor_missing;
    logic freq_resistor_missing;
    logic boost_overcurrent;
    logic boost_overvolt_high;
    logic boost_overvolt_low;
  } fsr_boost_ev_t;
  // String fault events and live detail levels
  typedef struct packed {
    logic bus_timeout;
    logic bad_string_cfg;
    logic string_fault;
    logic string_ground_short;
    logic string_internal_short;
    logic string_open;
    logic [5:0] chan_fault;
  } fsr_string_ev_t;
endpackage : fsr_pkg

// file: fsr_bank.sv
// APB slave holding boost and string fault flags and the live state readout
//
// Our own choice: the APB slave port.
`timescale 1ns/1ps
module fsr_bank (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire fsr_pkg::fsr_boost_ev_t boost_ev,
  input wire fsr_pkg::fsr_string_ev_t string_ev,
  input wire logic [4:0] live_state_code,
  output logic fault_irq
);
  // Latched boost flags, bit k is status bit 2k+1
  logic [fsr_pkg::FSR_NB-1:0] boost_flag_r;
  logic [fsr_pkg::FSR_NB-1:0] boost_flag_nxt;
  // Latched string flags: 2 timeout, 1 bad config, 0 combined
  logic [fsr_pkg::FSR_NS-1:0] string_flag_r;
  logic [fsr_pkg::FSR_NS-1:0] string_flag_nxt;
  // Registered read-only detail bits and state
  logic [8:0] detail_r;
  logic [4:0] state_r;
  // Bus outputs
  logic [31:0] prdata_r;
  logic [31:0] prdata_nxt;
  logic irq_r;

  // Access decode
  wire access = psel & penable;
  // Write lands only on the edge that completes the access phase
  wire wr_take = access & pwrite & pready;
  wire wr_lo = wr_take & pstrb[0];
  wire wr_hi = wr_take & pstrb[1];
  wire hit_boost = (paddr == fsr_pkg::FSR_ADDR_BOOST);
  wire hit_string = (paddr == fsr_pkg::FSR_ADDR_STRING);
  wire hit_state = (paddr == fsr_pkg::FSR_ADDR_STATE);
  wire unmapped = ~(hit_boost | hit_string | hit_state);
  // Write data masked by byte strobes
  wire [15:0] wmask = {{8{wr_hi}}, {8{wr_lo}}};
  wire [15:0] wd = pwdata[15:0] & wmask;

  // Pairwise clear: a status bit and its clear bit both written with one
  function automatic logic [fsr_pkg::FSR_NB-1:0] pair_clr(input logic [15:0] d);
    logic [fsr_pkg::FSR_NB-1:0] c;
    c = '0;
    for (int k = 0; k < fsr_pkg::FSR_NB; k++)
    begin
      c[k] = d[2*k+1] & d[2*k];
    end
    return c;
  endfunction : pair_clr

  // Boost clear vector, bit k pairs bits 2k+1 and 2k
  wire [fsr_pkg::FSR_NB-1:0] boost_clr = hit_boost ? pair_clr(wd) : '0;
  // String clear: pairs 14/13, 12/11, 10/9, shifted down by nine
  wire [15:0] wd_s = wd >> 9;
  wire [fsr_pkg::FSR_NB-1:0] string_pairs = pair_clr(wd_s);
  wire [fsr_pkg::FSR_NS-1:0] string_clr = hit_string ? string_pairs[2:0] : '0;
  // Events mapped onto flag vectors
  wire [fsr_pkg::FSR_NB-1:0] boost_set = boost_ev;
  wire [fsr_pkg::FSR_NS-1:0] string_set = {string_ev.bus_timeout, string_ev.bad_string_cfg,
                                           string_ev.string_fault};
  // Next flags: set wins over clear
  assign boost_flag_nxt = (boost_flag_r & ~boost_clr) | boost_set;
  assign string_flag_nxt = (string_flag_r & ~string_clr) | string_set;

  // Spread boost flags to odd bits, clear bits read zero
  function automatic logic [15:0] spread(input logic [fsr_pkg::FSR_NB-1:0] f);
    logic [15:0] v;
    v = '0;
    for (int k = 0; k < fsr_pkg::FSR_NB; k++)
    begin
      v[2*k+1] = f[k];
    end
    return v;
  endfunction : spread

  // Read views of each register
  wire [15:0] boost_view = spread(boost_flag_r);
  wire [15:0] string_view = {1'b0, string_flag_r[2], 1'b0, string_flag_r[1], 1'b0,
                             string_flag_r[0], 1'b0, detail_r};
  wire [15:0] state_view = {11'h000, state_r};
  assign prdata_nxt = ~(access & ~pwrite) ? prdata_r :
                      hit_boost ? {16'h0000, boost_view} :
                      hit_string ? {16'h0000, string_view} :
                      hit_state ? {16'h0000, state_view} : 32'h0000_0000;

  // Flag latches
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      boost_flag_r <= '0;
      string_flag_r <= '0;
    end
    else
    begin
      boost_flag_r <= boost_flag_nxt;
      string_flag_r <= string_flag_nxt;
    end
  end

  // Live detail and state sampling
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      detail_r <= '0;
      state_r <= fsr_pkg::FSR_ST_DISABLED;
    end
    else
    begin
      detail_r <= {string_ev.string_ground_short, string_ev.string_internal_short,
                   string_ev.string_open, string_ev.chan_fault};
      state_r <= live_state_code;
    end
  end

  // Bus answer and interrupt output registers
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata_r <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
      irq_r <= 1'b0;
    end
    else
    begin
      prdata_r <= prdata_nxt;
      // Ready pulses once per access phase, one wait state
      pready <= psel & penable & ~pready;
      pslverr <= psel & penable & ~pready & unmapped;
      irq_r <= |{boost_flag_nxt, string_flag_nxt};
    end
  end

  assign prdata = prdata_r;
  assign fault_irq = irq_r;

  // Assertions
  sequence s_clear_pair;
    access & pready & pwrite & hit_boost & wr_hi & pwdata[15] & pwdata[14]
      & ~boost_ev.thermal_shutdown;
  endsequence

  AST_THERMAL_SHUTDOWN_CLR: assert property (@(posedge pclk) disable iff (!presetn)
    s_clear_pair |=> ~boost_flag_r[7]) else $error("thermal flag not cleared");
  AST_LONE_CLEAR: assert property (@(posedge pclk) disable iff (!presetn)
    (boost_flag_r[7] & ~(access & hit_boost & wd[15] & wd[14])) |=> boost_flag_r[7])
    else $error("thermal flag lost without paired clear");
  AST_SET_WINS: assert property (@(posedge pclk) disable iff (!presetn)
    boost_ev.boost_overcurrent |=> boost_flag_r[2]) else $error("event lost");
  AST_IRQ: assert property (@(posedge pclk) disable iff (!presetn)
    ((|boost_flag_r) | (|string_flag_r)) == fault_irq) else $error("irq mismatch");
  AST_STR_CLEAR: assert property (@(posedge pclk) disable iff (!presetn)
    (access & pwrite & hit_string & wd[10] & wd[9] & ~string_ev.string_fault)
    |=> ~string_flag_r[0]) else $error("combined flag not cleared");
  AST_STATE_RO: assert property (@(posedge pclk) disable iff (!presetn)
    (access & ~pwrite & hit_state) |=> prdata[31:5] == 27'h0) else $error("reserved nonzero");
  AST_STATE_VAL: assert property (@(posedge pclk) disable iff (!presetn)
    (access & ~pwrite & hit_state) |=> prdata[4:0] == $past(state_r)) else $error("bad state");
  AST_BOOST_RD: assert property (@(posedge pclk) disable iff (!presetn)
    (access & ~pwrite & hit_boost) |=> prdata[15:0] == $past(boost_view))
    else $error("bad boost read");
  AST_READY: assert property (@(posedge pclk) disable iff (!presetn)
    (psel & penable & ~pready) |=> pready) else $error("no ready");

  // Per-flag checks: paired clear drops, lone clear holds, event sets
  // Clear antecedents exclude a same-cycle event, since the set wins

  // Current resistor short cleared by its pair
  AST_B6_CLR: assert property (@(posedge pclk) disable iff (!presetn)
    (hit_boost & wd[13] & wd[12] & ~boost_ev[6]) |=> ~boost_flag_r[6])
    else $error("current resistor flag not cleared");

  // String resistor missing cleared by its pair
  AST_B5_CLR: assert property (@(posedge pclk) disable iff (!presetn)
    (hit_boost & wd[11] & wd[10] & ~boost_ev[5]) |=> ~boost_flag_r[5])
    else $error("string resistor flag not cleared");

  // Mode resistor missing cleared by its pair
  AST_B4_CLR: assert property (@(posedge pclk) disable iff (!presetn)
    (hit_boost & wd[9] & wd[8] & ~boost_ev[4]) |=> ~boost_flag_r[4])
    else $error("mode resistor flag not cleared");

  // Frequency resistor missing cleared by its pair
  AST_B3_CLR: assert property (@(posedge pclk) disable iff (!presetn)
    (hit_boost & wd[7] & wd[6] & ~boost_ev[3]) |=> ~boost_flag_r[3])
    else $error("frequency resistor flag not cleared");

  // Overcurrent cleared by its pair
  AST_B2_CLR: assert property (@(posedge pclk) disable iff (!presetn)
    (hit_boost & wd[5] & wd[4] & ~boost_ev[2]) |=> ~boost_flag_r[2])
    else $error("overcurrent flag not cleared");

  // Overvoltage high cleared by its pair
  AST_B1_CLR: assert property (@(posedge pclk) disable iff (!presetn)
    (hit_boost & wd[3] & wd[2] & ~boost_ev[1]) |=> ~boost_flag_r[1])
    else $error("overvoltage high flag not cleared");

  // Overvoltage low cleared by its pair
  AST_B0_CLR: assert property (@(posedge pclk) disable iff (!presetn)
    (hit_boost & wd[1] & wd[0] & ~boost_ev[0]) |=> ~boost_flag_r[0])
    else $error("overvoltage low flag not cleared");

  // Current resistor short holds without its pair
  AST_B6_HOLD: assert property (@(posedge pclk) disable iff (!presetn)
    (boost_flag_r[6] & ~(hit_boost & wd[13] & wd[12])) |=> boost_flag_r[6])
    else $error("current resistor flag lost");

  // String resistor missing holds without its pair
  AST_B5_HOLD: assert property (@(posedge pclk) disable iff (!presetn)
    (boost_flag_r[5] & ~(hit_boost & wd[11] & wd[10])) |=> boost_flag_r[5])
    else $error("string resistor flag lost");

  // Mode resistor missing holds without its pair
  AST_B4_HOLD: assert property (@(posedge pclk) disable iff (!presetn)
    (boost_flag_r[4] & ~(hit_boost & wd[9] & wd[8])) |=> boost_flag_r[4])
    else $error("mode resistor flag lost");

  // Frequency resistor missing holds without its pair
  AST_B3_HOLD: assert property (@(posedge pclk) disable iff (!presetn)
    (boost_flag_r[3] & ~(hit_boost & wd[7] & wd[6])) |=> boost_flag_r[3])
    else $error("frequency resistor flag lost");

  // Overcurrent holds without its pair
  AST_B2_HOLD: assert property (@(posedge pclk) disable iff (!presetn)
    (boost_flag_r[2] & ~(hit_boost & wd[5] & wd[4])) |=> boost_flag_r[2])
    else $error("overcurrent flag lost");

  // Overvoltage high holds without its pair
  AST_B1_HOLD: assert property (@(posedge pclk) disable iff (!presetn)
    (boost_flag_r[1] & ~(hit_boost & wd[3] & wd[2])) |=> boost_flag_r[1])
    else $error("overvoltage high flag lost");

  // Overvoltage low holds without its pair
  AST_B0_HOLD: assert property (@(posedge pclk) disable iff (!presetn)
    (boost_flag_r[0] & ~(hit_boost & wd[1] & wd[0])) |=> boost_flag_r[0])
    else $error("overvoltage low flag lost");

  // Thermal event latches
  AST_B7_SET: assert property (@(posedge pclk) disable iff (!presetn)
    boost_ev.thermal_shutdown |=> boost_flag_r[7])
    else $error("thermal event lost");

  // Current resistor event latches
  AST_B6_SET: assert property (@(posedge pclk) disable iff (!presetn)
    boost_ev.current_resistor_short |=> boost_flag_r[6])
    else $error("current resistor event lost");

  // String resistor event latches
  AST_B5_SET: assert property (@(posedge pclk) disable iff (!presetn)
    boost_ev.string_cfg_resistor_missing |=> boost_flag_r[5])
    else $error("string resistor event lost");

  // Mode resistor event latches
  AST_B4_SET: assert property (@(posedge pclk) disable iff (!presetn)
    boost_ev.mode_resistor_missing |=> boost_flag_r[4])
    else $error("mode resistor event lost");

  // Frequency resistor event latches
  AST_B3_SET: assert property (@(posedge pclk) disable iff (!presetn)
    boost_ev.freq_resistor_missing |=> boost_flag_r[3])
    else $error("frequency resistor event lost");

  // Overvoltage high event latches
  AST_B1_SET: assert property (@(posedge pclk) disable iff (!presetn)
    boost_ev.boost_overvolt_high |=> boost_flag_r[1])
    else $error("overvoltage high event lost");

  // Overvoltage low event latches
  AST_B0_SET: assert property (@(posedge pclk) disable iff (!presetn)
    boost_ev.boost_overvolt_low |=> boost_flag_r[0])
    else $error("overvoltage low event lost");

  // Bus timeout cleared by its pair
  AST_S2_CLR: assert property (@(posedge pclk) disable iff (!presetn)
    (hit_string & wd[14] & wd[13] & ~string_ev.bus_timeout) |=> ~string_flag_r[2])
    else $error("bus timeout flag not cleared");

  // Bad configuration cleared by its pair
  AST_S1_CLR: assert property (@(posedge pclk) disable iff (!presetn)
    (hit_string & wd[12] & wd[11] & ~string_ev.bad_string_cfg) |=> ~string_flag_r[1])
    else $error("bad configuration flag not cleared");

  // Bus timeout holds without its pair
  AST_S2_HOLD: assert property (@(posedge pclk) disable iff (!presetn)
    (string_flag_r[2] & ~(hit_string & wd[14] & wd[13])) |=> string_flag_r[2])
    else $error("bus timeout flag lost");

  // Bad configuration holds without its pair
  AST_S1_HOLD: assert property (@(posedge pclk) disable iff (!presetn)
    (string_flag_r[1] & ~(hit_string & wd[12] & wd[11])) |=> string_flag_r[1])
    else $error("bad configuration flag lost");

  // Combined string flag holds without its pair
  AST_S0_HOLD: assert property (@(posedge pclk) disable iff (!presetn)
    (string_flag_r[0] & ~(hit_string & wd[10] & wd[9])) |=> string_flag_r[0])
    else $error("combined flag lost");

  // Bus timeout event latches
  AST_S2_SET: assert property (@(posedge pclk) disable iff (!presetn)
    string_ev.bus_timeout |=> string_flag_r[2])
    else $error("bus timeout event lost");

  // Bad configuration event latches
  AST_S1_SET: assert property (@(posedge pclk) disable iff (!presetn)
    string_ev.bad_string_cfg |=> string_flag_r[1])
    else $error("bad configuration event lost");

  // Combined string event latches
  AST_S0_SET: assert property (@(posedge pclk) disable iff (!presetn)
    string_ev.string_fault |=> string_flag_r[0])
    else $error("combined event lost");

  // String read returns its view, reserved bit low
  AST_STR_RD: assert property (@(posedge pclk) disable iff (!presetn)
    (access & ~pwrite & hit_string) |=> (prdata[15:0] == $past(string_view)) & ~prdata[15])
    else $error("bad string read");

  // Open string detail bit goes high one cycle after its live level
  AST_DETAIL: assert property (@(posedge pclk) disable iff (!presetn)
    string_ev.string_open |=> detail_r[6])
    else $error("open string level not sampled");

  // Boost read upper half stays zero
  AST_BOOST_HI: assert property (@(posedge pclk) disable iff (!presetn)
    (access & ~pwrite & hit_boost) |=> prdata[31:16] == 16'h0000)
    else $error("boost upper half nonzero");

  // Unmapped access answers with an error
  AST_ERR: assert property (@(posedge pclk) disable iff (!presetn)
    (access & ~pready & unmapped) |=> pslverr)
    else $error("missing error response");

  // Mapped access answers without an error
  AST_NO_ERR: assert property (@(posedge pclk) disable iff (!presetn)
    (access & ~pready & ~unmapped) |=> ~pslverr)
    else $error("spurious error response");

  // Ready is a single-cycle pulse
  AST_READY_PULSE: assert property (@(posedge pclk) disable iff (!presetn)
    pready |=> ~pready)
    else $error("ready held too long");

  // Interrupt drops once nothing stays latched
  AST_IRQ_DROP: assert property (@(posedge pclk) disable iff (!presetn)
    (~(|boost_flag_nxt) & ~(|string_flag_nxt)) |=> ~fault_irq)
    else $error("interrupt stuck high");
endmodule : fsr_bank

// file: fsr_tb.sv
// Self-checking bench for the fault status and state readout bank
`timescale 1ns/1ps
`define CHK(nm, e, g) begin tests_run++; if ((g) !== (e)) begin n_fail++; \
  $display("CHECK FAILED %s exp %h got %h", nm, e, g); end end
module testbench;
  logic pclk = 1'b0; // Bus clock, 50 ns
  logic presetn = 1'b0; // Async reset, active low
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [3:0] pstrb = 4'hf;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic fault_irq;
  fsr_pkg::fsr_boost_ev_t boost_ev = '0; // Boost fault events
  fsr_pkg::fsr_string_ev_t string_ev = '0; // String events and levels
  logic [4:0] live_state_code = 5'h00;
  logic [31:0] rd; // Data of the last transfer
  logic er; // Error response of the last transfer
  int n_fail = 0;
  int tests_run = 0;
  // Free running clock
  always #25 pclk = ~pclk;
  fsr_bank uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .boost_ev(boost_ev), .string_ev(string_ev),
    .live_state_code(live_state_code), .fault_irq(fault_irq));
  // Print counts and verdict, then stop
  task automatic summarize();
    $display("Counts: %0d mismatches in %0d checks", n_fail, tests_run);
    if (n_fail == 0 && tests_run > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : summarize
  // One APB transfer; waits for pready under a bound
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int i;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    i = 0;
    do
    begin
      @(posedge pclk);
      i++;
    end
    while (pready !== 1'b1 && i < 20);
    if (pready !== 1'b1)
    begin
      n_fail++;
      summarize();
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  // Reset values of all three registers
  task automatic t_reset();
    apb(1'b0, fsr_pkg::FSR_ADDR_BOOST, 32'h0);
    `CHK("boost reset", 32'h0000_0000, rd)
    apb(1'b0, fsr_pkg::FSR_ADDR_STRING, 32'h0);
    `CHK("string reset", 32'h0000_0000, rd)
    apb(1'b0, fsr_pkg::FSR_ADDR_STATE, 32'h0);
    `CHK("state reset", 32'h0000_0000, rd)
    `CHK("irq reset", 1'b0, fault_irq)
  endtask : t_reset
  // Latch, lone clear, strobed-off clear and paired clear of one flag
  task automatic flag_cycle(input logic [11:0] a, input int ev, input int pos, input bit b);
    @(posedge pclk);
    if (b) boost_ev[ev] <= 1'b1; else string_ev[ev] <= 1'b1;
    @(posedge pclk);
    if (b) boost_ev[ev] <= 1'b0; else string_ev[ev] <= 1'b0;
    repeat (2) @(posedge pclk);
    `CHK("irq set", 1'b1, fault_irq)
    apb(1'b0, a, 32'h0);
    `CHK("flag set", 32'h1 << pos, rd)
    apb(1'b1, a, 32'h1 << (pos - 1));
    apb(1'b0, a, 32'h0);
    `CHK("lone clear", 32'h1 << pos, rd)
    pstrb <= 4'h0;
    apb(1'b1, a, 32'h3 << (pos - 1));
    pstrb <= 4'hf;
    apb(1'b0, a, 32'h0);
    `CHK("strobe off", 32'h1 << pos, rd)
    apb(1'b1, a, 32'h3 << (pos - 1));
    apb(1'b0, a, 32'h0);
    `CHK("paired clear", 32'h0, rd)
    `CHK("irq clear", 1'b0, fault_irq)
  endtask : flag_cycle
  // Every clearable flag of both registers
  task automatic t_flags();
    for (int i = 0; i < 8; i++) flag_cycle(fsr_pkg::FSR_ADDR_BOOST, i, 2 * i + 1, 1'b1);
    for (int k = 0; k < 3; k++) flag_cycle(fsr_pkg::FSR_ADDR_STRING, 9 + k, 10 + 2 * k, 1'b0);
  endtask : t_flags
  // Read-only detail bits follow levels; writes and reserved bit do nothing
  task automatic t_detail();
    string_ev[8:0] <= 9'h155;
    repeat (3) @(posedge pclk);
    apb(1'b1, fsr_pkg::FSR_ADDR_STRING, 32'h0000_81ff);
    apb(1'b0, fsr_pkg::FSR_ADDR_STRING, 32'h0);
    `CHK("detail a", 32'h0000_0155, rd)
    string_ev[8:0] <= 9'h0aa;
    repeat (3) @(posedge pclk);
    apb(1'b0, fsr_pkg::FSR_ADDR_STRING, 32'h0);
    `CHK("detail b", 32'h0000_00aa, rd)
    `CHK("irq detail", 1'b0, fault_irq)
    string_ev[8:0] <= 9'h000;
  endtask : t_detail
  // Every state code reads back live with upper bits zero
  task automatic t_state();
    for (int c = 0; c < 20; c++)
    begin
      live_state_code <= c[4:0];
      repeat (2) @(posedge pclk);
      apb(1'b0, fsr_pkg::FSR_ADDR_STATE, 32'h0);
      `CHK("state code", {27'h0, c[4:0]}, rd)
    end
  endtask : t_state
  // Unmapped address, then reset in mid-run clears a latched flag
  task automatic t_misc();
    apb(1'b0, 12'h044, 32'h0);
    `CHK("unmapped err", 1'b1, er)
    `CHK("unmapped data", 32'h0, rd)
    @(posedge pclk);
    boost_ev[7] <= 1'b1;
    @(posedge pclk);
    boost_ev[7] <= 1'b0;
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, fsr_pkg::FSR_ADDR_BOOST, 32'h0);
    `CHK("reset clears", 32'h0, rd)
  endtask : t_misc
  // Main sequence
  initial
  begin
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_flags();
    t_detail();
    t_state();
    t_misc();
    summarize();
  end
endmodule : testbench
